// [iimc_defines.svh]
/*
 Constants for the input interrupt mask control block: control codes,
 field positions, reset values and the number of inputs.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef IIMC_DEFINES_SVH
`define IIMC_DEFINES_SVH

`define IIMC_NUM_IN 4
`define IIMC_CODE_W 12
`define IIMC_DATA_W 16
`define IIMC_SV_W 16

// Control codes, held as three-digit packed decimal
`define IIMC_CC_MASK 12'h000
`define IIMC_CC_CLEAR 12'h001
`define IIMC_CC_READ 12'h002
`define IIMC_CC_RENEW 12'h003
`define IIMC_CC_ALL_MASK 12'h100
`define IIMC_CC_ALL_UNMASK 12'h200

// Data field layout
`define IIMC_SEL_LSB 0
`define IIMC_SEL_MSB 3
`define IIMC_RSV_LSB 4
`define IIMC_RSV_MSB 15

// Reset values
`define IIMC_MASK_RST 4'h0
`define IIMC_PEND_RST 4'h0
`define IIMC_SV_RST 16'h0000
`define IIMC_WORD_RST 16'h0000
`define IIMC_ZERO_DATA 16'h0000
`define IIMC_ZERO_SEL 4'h0

`endif

// [iimc_pkg.sv]
/*
 Types for the input interrupt mask control block.
 Assumes iimc_defines.svh is on the include path.
*/
`include "iimc_defines.svh"

package iimc_pkg;

   // Decoded command function
   typedef enum logic [2:0] {
      IIMC_FN_MASK = 3'h0,
      IIMC_FN_CLEAR = 3'h1,
      IIMC_FN_READ = 3'h2,
      IIMC_FN_RENEW = 3'h3,
      IIMC_FN_ALL_MASK = 3'h4,
      IIMC_FN_ALL_UNMASK = 3'h5,
      IIMC_FN_BAD = 3'h6
   } iimc_fn_t;

endpackage : iimc_pkg

// [iimc_cmd_if.sv]
/*
 Interface carrying one decoded command from the decoder to the core.
 Assumes a single clock; all signals are combinational from the decoder.
*/
`timescale 1ns/1ps
`include "iimc_defines.svh"

interface iimc_cmd_if;
   logic go;
   iimc_pkg::iimc_fn_t fn;
   logic [`IIMC_NUM_IN-1:0] sel;
   logic data_bad;

   modport dec (output go, output fn, output sel, output data_bad);
   modport core (input go, input fn, input sel, input data_bad);
endinterface : iimc_cmd_if

// [iimc_decode.sv]
/*
 Command decoder: turns control code and data word into a function,
 a select vector and a data-range check.
 Assumes inputs are synchronous to the core clock.
*/
`timescale 1ns/1ps
`include "iimc_defines.svh"

module iimc_decode (
   input wire logic cmd_valid,
   input wire logic exec_cond,
   input wire logic [`IIMC_CODE_W-1:0] control_code,
   input wire logic [`IIMC_DATA_W-1:0] control_data,
   iimc_cmd_if.dec cmd
);

   ////////////////////////////////////////////////////////////////////////
   // Only a command with its condition true does anything
   assign cmd.go = cmd_valid & exec_cond;
   assign cmd.sel = control_data[`IIMC_SEL_MSB:`IIMC_SEL_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Code to function; unknown codes become the error function
   always_comb begin
      cmd.fn = iimc_pkg::IIMC_FN_BAD;
      cmd.data_bad = 1'b0;
      case (control_code)
         `IIMC_CC_MASK: begin
            cmd.fn = iimc_pkg::IIMC_FN_MASK;
            cmd.data_bad =
               |control_data[`IIMC_RSV_MSB:`IIMC_RSV_LSB];
         end
         `IIMC_CC_CLEAR: begin
            cmd.fn = iimc_pkg::IIMC_FN_CLEAR;
            cmd.data_bad =
               |control_data[`IIMC_RSV_MSB:`IIMC_RSV_LSB];
         end
         `IIMC_CC_READ: begin
            cmd.fn = iimc_pkg::IIMC_FN_READ;
         end
         `IIMC_CC_RENEW: begin
            cmd.fn = iimc_pkg::IIMC_FN_RENEW;
            cmd.data_bad =
               |control_data[`IIMC_RSV_MSB:`IIMC_RSV_LSB];
         end
         `IIMC_CC_ALL_MASK: begin
            cmd.fn = iimc_pkg::IIMC_FN_ALL_MASK;
            cmd.data_bad = control_data != `IIMC_ZERO_DATA;
         end
         `IIMC_CC_ALL_UNMASK: begin
            cmd.fn = iimc_pkg::IIMC_FN_ALL_UNMASK;
            cmd.data_bad = control_data != `IIMC_ZERO_DATA;
         end
         default: begin
            cmd.fn = iimc_pkg::IIMC_FN_BAD;
         end
      endcase
   end

endmodule : iimc_decode

// [iimc_pending.sv]
/*
 Per-input pending latches with edge detection and clear.
 Assumes irq_in is synchronous to clk; active edge is rising.
*/
`timescale 1ns/1ps
`include "iimc_defines.svh"

module iimc_pending (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [`IIMC_NUM_IN-1:0] irq_in,
   input wire logic [`IIMC_NUM_IN-1:0] clr,
   input wire logic [`IIMC_NUM_IN-1:0] taken,
   output logic [`IIMC_NUM_IN-1:0] pend
);

   logic [`IIMC_NUM_IN-1:0] irq_d_r;
   logic [`IIMC_NUM_IN-1:0] pend_r;

   ////////////////////////////////////////////////////////////////////////
   // Previous input level for edge detection
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_d_r <= `IIMC_PEND_RST;
      end else begin
         irq_d_r <= irq_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One latch per input; a new edge wins over clear or service
   genvar i;
   generate
      for (i = 0; i < `IIMC_NUM_IN; i = i + 1) begin : g_pend
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               pend_r[i] <= 1'b0;
            end else if (irq_in[i] & ~irq_d_r[i]) begin
               pend_r[i] <= 1'b1;
            end else if (clr[i] | taken[i]) begin
               pend_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign pend = pend_r;

endmodule : iimc_pending

// [iimc_top.sv]
/*
 Input interrupt mask control: command execution, per-input and global
 masks, pending latches, service requests and counter set value reload.
 Assumes one clock; commands, acknowledges and inputs are synchronous.
*/
`timescale 1ns/1ps
`include "iimc_defines.svh"

module iimc_top (
   clk,
   reset_n,
   cmd_valid,
   exec_cond,
   control_code,
   control_data,
   irq_in,
   svc_busy,
   svc_ack,
   sv_new,
   sv_new_ok,
   irq_req,
   counter_set_value,
   read_word,
   read_valid,
   error_flag,
   input_mask,
   all_masked
);
   input wire logic clk;
   input wire logic reset_n;
   input wire logic cmd_valid;
   input wire logic exec_cond;
   input wire logic [`IIMC_CODE_W-1:0] control_code;
   input wire logic [`IIMC_DATA_W-1:0] control_data;
   input wire logic [`IIMC_NUM_IN-1:0] irq_in;
   input wire logic svc_busy;
   input wire logic [`IIMC_NUM_IN-1:0] svc_ack;
   input wire logic [`IIMC_NUM_IN*`IIMC_SV_W-1:0] sv_new;
   input wire logic [`IIMC_NUM_IN-1:0] sv_new_ok;
   output logic [`IIMC_NUM_IN-1:0] irq_req;
   output logic [`IIMC_NUM_IN*`IIMC_SV_W-1:0] counter_set_value;
   output logic [`IIMC_DATA_W-1:0] read_word;
   output logic read_valid;
   output logic error_flag;
   output logic [`IIMC_NUM_IN-1:0] input_mask;
   output logic all_masked;

   iimc_cmd_if cmd ();

   logic [`IIMC_NUM_IN-1:0] mask_r;
   logic all_mask_r;
   logic error_r;
   logic [`IIMC_DATA_W-1:0] read_word_r;
   logic read_valid_r;
   logic [`IIMC_NUM_IN*`IIMC_SV_W-1:0] sv_r;
   logic [`IIMC_NUM_IN-1:0] pend;
   logic [`IIMC_NUM_IN-1:0] clr;
   logic [`IIMC_NUM_IN-1:0] taken;
   logic [`IIMC_NUM_IN-1:0] renew_sel;
   logic error_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Command decoder and pending latches
   iimc_decode u_decode (
      .cmd_valid(cmd_valid),
      .exec_cond(exec_cond),
      .control_code(control_code),
      .control_data(control_data),
      .cmd(cmd)
   );

   iimc_pending u_pending (
      .clk(clk),
      .reset_n(reset_n),
      .irq_in(irq_in),
      .clr(clr),
      .taken(taken),
      .pend(pend)
   );

   ////////////////////////////////////////////////////////////////////////
   // Strobes derived from a legal executed command
   wire ok_cmd = cmd.go & ~cmd.data_bad;
   assign clr = (ok_cmd && cmd.fn == iimc_pkg::IIMC_FN_CLEAR) ?
                cmd.sel : `IIMC_ZERO_SEL;
   assign renew_sel = (ok_cmd && cmd.fn == iimc_pkg::IIMC_FN_RENEW) ?
                      cmd.sel : `IIMC_ZERO_SEL;

   // Request stays up until acknowledged or cleared; masked ones wait in the latch
   assign irq_req = pend & ~mask_r & {`IIMC_NUM_IN{~all_mask_r}};
   assign taken = svc_ack & irq_req;

   ////////////////////////////////////////////////////////////////////////
   // Per-input mask
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mask_r <= `IIMC_MASK_RST;
      end else if (ok_cmd && cmd.fn == iimc_pkg::IIMC_FN_MASK) begin
         mask_r <= cmd.sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Global mask; the redundant and busy cases are refused
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         all_mask_r <= 1'b0;
      end else if (ok_cmd && !svc_busy) begin
         if (cmd.fn == iimc_pkg::IIMC_FN_ALL_MASK) begin
            all_mask_r <= 1'b1;
         end else if (cmd.fn == iimc_pkg::IIMC_FN_ALL_UNMASK) begin
            all_mask_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Error of the current command; reflects only the last executed one
   always_comb begin
      error_nxt = 1'b0;
      if (cmd.go) begin
         if (cmd.data_bad || cmd.fn == iimc_pkg::IIMC_FN_BAD) begin
            error_nxt = 1'b1;
         end else if (cmd.fn == iimc_pkg::IIMC_FN_RENEW) begin
            error_nxt = |(cmd.sel & ~sv_new_ok);
         end else if (cmd.fn == iimc_pkg::IIMC_FN_ALL_MASK) begin
            error_nxt = svc_busy | all_mask_r;
         end else if (cmd.fn == iimc_pkg::IIMC_FN_ALL_UNMASK) begin
            error_nxt = svc_busy | ~all_mask_r;
         end
      end
   end

   // Flag holds until the next executed command
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         error_r <= 1'b0;
      end else if (cmd.go) begin
         error_r <= error_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mask readback word, a one-cycle strobe marks it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         read_word_r <= `IIMC_WORD_RST;
         read_valid_r <= 1'b0;
      end else begin
         read_valid_r <= ok_cmd && cmd.fn == iimc_pkg::IIMC_FN_READ;
         if (ok_cmd && cmd.fn == iimc_pkg::IIMC_FN_READ) begin
            read_word_r <= `IIMC_WORD_RST;
            read_word_r[`IIMC_SEL_MSB:`IIMC_SEL_LSB] <= mask_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter set values; an invalid new value is not loaded
   genvar k;
   generate
      for (k = 0; k < `IIMC_NUM_IN; k = k + 1) begin : g_sv
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               sv_r[k*`IIMC_SV_W +: `IIMC_SV_W] <= `IIMC_SV_RST;
            end else if (renew_sel[k] && sv_new_ok[k]) begin
               sv_r[k*`IIMC_SV_W +: `IIMC_SV_W] <=
                  sv_new[k*`IIMC_SV_W +: `IIMC_SV_W];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign counter_set_value = sv_r;
   assign read_word = read_word_r;
   assign read_valid = read_valid_r;
   assign error_flag = error_r;
   assign input_mask = mask_r;
   assign all_masked = all_mask_r;

endmodule : iimc_top

// [iimc_chk_sva.sv]
/*
 Port checker for iimc_top, bound to every instance of it.
 Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "iimc_defines.svh"
module iimc_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic exec_cond,
   input wire logic [11:0] control_code,
   input wire logic [15:0] control_data,
   input wire logic [3:0] irq_in,
   input wire logic svc_busy,
   input wire logic [3:0] svc_ack,
   input wire logic [63:0] sv_new,
   input wire logic [3:0] sv_new_ok,
   input wire logic [3:0] irq_req,
   input wire logic [63:0] counter_set_value,
   input wire logic [15:0] read_word,
   input wire logic read_valid,
   input wire logic error_flag,
   input wire logic [3:0] input_mask,
   input wire logic all_masked
);
   // Command decode seen from the pins
   wire ex = cmd_valid && exec_cond;
   wire hi = |control_data[15:4];
   wire am = control_code == `IIMC_CC_ALL_MASK;
   wire glb = am || control_code == `IIMC_CC_ALL_UNMASK;
   // Rising input edges as the pending latches see them
   logic [3:0] irq_q_r;
   always_ff @(posedge clk) irq_q_r <= irq_in;
   wire [3:0] rise = irq_in & ~irq_q_r;
   wire [3:0] fresh = rise & ~input_mask;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////
   chk_req_gated: assert property (
      (irq_req & (input_mask | {4{all_masked}})) == 4'h0)
      else $error("request shown on a masked input");
   chk_read_word: assert property (
      ex && control_code == `IIMC_CC_READ |=> read_valid && !error_flag
      && read_word == {12'h000, $past(input_mask)})
      else $error("mask readback wrong");
   chk_idle_hold: assert property (
      !ex |=> $stable(error_flag) && $stable(input_mask) && !read_valid
      && $stable(all_masked) && $stable(counter_set_value))
      else $error("state moved without an executed command");
   chk_mask_write: assert property (
      ex && control_code == `IIMC_CC_MASK && !hi |=> !error_flag
      && input_mask == $past(control_data[3:0]))
      else $error("mask write wrong");
   chk_data_bad: assert property (
      ex && hi && control_code inside {`IIMC_CC_MASK, `IIMC_CC_CLEAR,
      `IIMC_CC_RENEW} |=> error_flag && $stable(input_mask))
      else $error("upper data bits not refused");
   chk_glb_busy: assert property (
      ex && glb && svc_busy |=> error_flag && $stable(all_masked))
      else $error("global command during service not refused");
   chk_glb_twice: assert property (
      ex && glb && all_masked == am |=> error_flag && $stable(all_masked))
      else $error("redundant global command not refused");
   chk_glb_set: assert property (
      ex && glb && !svc_busy && control_data == 16'h0000
      && all_masked != am |=> !error_flag && all_masked == $past(am))
      else $error("global mask not changed");
   chk_renew_bad: assert property (
      ex && control_code == `IIMC_CC_RENEW
      && (control_data[3:0] & ~sv_new_ok) != 4'h0 |=> error_flag)
      else $error("invalid set value not flagged");
   chk_code_bad: assert property (
      ex && !(glb || control_code <= `IIMC_CC_RENEW) |=> error_flag
      && $stable(input_mask) && $stable(all_masked))
      else $error("unknown code not refused");
   chk_edge_serve: assert property (
      !ex && !all_masked && fresh != 4'h0
      |=> (irq_req & $past(fresh)) == $past(fresh))
      else $error("unmasked edge not requested");
   chk_clear_drop: assert property (
      ex && control_code == `IIMC_CC_CLEAR && !hi
      && (rise & control_data[3:0]) == 4'h0
      |=> (irq_req & $past(control_data[3:0])) == 4'h0)
      else $error("cleared request still shown");
   // Main scenarios reached
   cover property (ex && control_code == `IIMC_CC_READ);
   cover property (ex && glb ##1 !error_flag);
   cover property (irq_req != 4'h0 ##1 svc_ack != 4'h0);
endmodule : iimc_chk
bind iimc_top iimc_chk chk_u (.clk(clk), .reset_n(reset_n),
   .cmd_valid(cmd_valid), .exec_cond(exec_cond), .irq_in(irq_in),
   .control_code(control_code), .control_data(control_data),
   .svc_busy(svc_busy), .svc_ack(svc_ack), .sv_new(sv_new),
   .sv_new_ok(sv_new_ok), .irq_req(irq_req), .read_word(read_word),
   .counter_set_value(counter_set_value), .read_valid(read_valid),
   .error_flag(error_flag), .input_mask(input_mask),
   .all_masked(all_masked));

// [iimc_exec_model.sv]
/*
 Program executor model: takes presented service requests.
 Assumes the request vector is settled before each rising edge.
*/
`timescale 1ns/1ps
module iimc_exec_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] lat,
   input wire logic [3:0] irq_req,
   output logic [3:0] svc_ack
);
   logic [1:0] wait_r;
   // Waits lat cycles, then acks all shown requests for one cycle
   always_ff @(posedge clk) begin
      if (!reset_n || svc_ack != 4'h0 || irq_req == 4'h0) begin
         wait_r <= 2'h0;
         svc_ack <= 4'h0;
      end else if (wait_r == lat) begin
         svc_ack <= irq_req;
      end else begin
         wait_r <= wait_r + 2'h1;
      end
   end
endmodule : iimc_exec_model

// [tb_input_interrupt_mask_control.sv]
/*
 Self-checking bench for iimc_top with the executor model.
 Assumes the checker is bound through its own file.
*/
`timescale 1ns/1ps
`include "iimc_defines.svh"
module tb_input_interrupt_mask_control;
   logic clk, reset_n, cmd_valid, exec_cond, svc_busy, read_valid;
   logic error_flag, all_masked, tk, g, bz_en;
   logic [11:0] control_code;
   logic [15:0] control_data, read_word, dd;
   logic [3:0] irq_in, svc_ack, sv_new_ok, irq_req, input_mask, m;
   logic [63:0] sv_new, counter_set_value, sv;
   logic [1:0] lat;
   logic [86:0] notes[$];
   logic [86:0] nt;
   logic [11:0] codes[8] = '{`IIMC_CC_MASK, `IIMC_CC_CLEAR, `IIMC_CC_READ,
      `IIMC_CC_RENEW, `IIMC_CC_ALL_MASK, `IIMC_CC_ALL_UNMASK, 12'h004,
      12'h300};
   int miscompares = 0;
   int n_checks = 0;
   iimc_top dut_u (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
      .exec_cond(exec_cond), .control_code(control_code), .irq_in(irq_in),
      .control_data(control_data), .svc_busy(svc_busy), .svc_ack(svc_ack),
      .sv_new(sv_new), .sv_new_ok(sv_new_ok), .irq_req(irq_req),
      .counter_set_value(counter_set_value), .read_word(read_word),
      .read_valid(read_valid), .error_flag(error_flag),
      .input_mask(input_mask), .all_masked(all_masked));
   iimc_exec_model exec_u (.clk(clk), .reset_n(reset_n), .lat(lat),
      .irq_req(irq_req), .svc_ack(svc_ack));
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   // Issues one command and notes what it should leave behind
   task cmd(input logic [11:0] c, input logic [15:0] d, input logic e);
      logic er, rd, bz;
      logic [3:0] ok;
      logic [63:0] nv;
      ok = 4'($urandom);
      nv = {$urandom, $urandom};
      bz = bz_en & $urandom;
      er = |d[15:4];
      rd = 1'h0;
      if (e) begin
         case (c)
            `IIMC_CC_MASK: if (!er) m = d[3:0];
            `IIMC_CC_CLEAR: rd = 1'h0;
            `IIMC_CC_READ: {er, rd} = 2'h1;
            `IIMC_CC_RENEW: begin
               for (int i = 0; i < 4; i++)
                  if (!er && d[i] && ok[i]) sv[16*i +: 16] = nv[16*i +: 16];
               er = er || (d[3:0] & ~ok) != 4'h0;
            end
            `IIMC_CC_ALL_MASK, `IIMC_CC_ALL_UNMASK: begin
               er = d != 16'h0000 || bz || g == (c == `IIMC_CC_ALL_MASK);
               if (!er) g = c == `IIMC_CC_ALL_MASK;
            end
            default: er = 1'h1;
         endcase
         notes.push_back({rd, er, g, m, 12'h000, m, sv});
      end
      control_code <= c;
      control_data <= d;
      exec_cond <= e;
      cmd_valid <= 1'h1;
      sv_new <= nv;
      sv_new_ok <= ok;
      svc_busy <= bz;
      @(posedge clk);
   endtask : cmd
   task idle(input int n);
      cmd_valid <= 1'h0;
      repeat (n) @(posedge clk);
   endtask : idle
   task look(input logic [3:0] exp);
      @(negedge clk);
      check(irq_req, exp);
      @(posedge clk);
   endtask : look
   // Result watcher: one note per executed command
   always @(posedge clk) tk <= cmd_valid && exec_cond && reset_n;
   always @(negedge clk) begin
      if (tk) begin
         nt = notes.pop_front();
         check(read_valid, nt[86]);
         check(error_flag, nt[85]);
         check({all_masked, input_mask}, nt[84:80]);
         if (nt[86]) check(read_word, nt[79:64]);
         check(counter_set_value, nt[63:0]);
      end
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      conclude();
   end
   // Random sweep, then directed pending and mask sequences
   initial begin
      {cmd_valid, exec_cond, svc_busy, tk, g, reset_n} = 6'h00;
      {control_code, control_data, irq_in, sv_new_ok, m} = 40'h0;
      {sv_new, sv, lat, bz_en} = 131'h0;
      void'($urandom(19));
      repeat (12) @(posedge clk);
      reset_n <= 1'h1;
      bz_en = 1'h1;
      @(posedge clk);
      for (int k = 0; k < 120; k++) begin
         case ($urandom % 3)
            0: dd = 16'($urandom);
            1: dd = 16'h0000;
            default: dd = 16'($urandom % 16);
         endcase
         irq_in <= 4'($urandom);
         lat <= 2'($urandom);
         cmd(codes[$urandom % 8], dd, $urandom % 8 != 0);
         if ($urandom % 5 == 0) idle(1);
      end
      bz_en = 1'h0;
      lat <= 2'h2;
      irq_in <= 4'h0;
      cmd(`IIMC_CC_ALL_UNMASK, 16'h0000, 1'h1);
      cmd(`IIMC_CC_MASK, 16'h000F, 1'h1);
      cmd(`IIMC_CC_CLEAR, 16'h000F, 1'h1);
      irq_in <= 4'h3;
      idle(3);
      look(4'h0);
      cmd(`IIMC_CC_CLEAR, 16'h0002, 1'h1);
      cmd(`IIMC_CC_MASK, 16'h000C, 1'h1);
      idle(0);
      look(4'h1);
      irq_in <= 4'h0;
      idle(5);
      look(4'h0);
      cmd(`IIMC_CC_ALL_MASK, 16'h0000, 1'h1);
      irq_in <= 4'h1;
      idle(3);
      look(4'h0);
      cmd(`IIMC_CC_ALL_UNMASK, 16'h0000, 1'h1);
      idle(0);
      look(4'h1);
      idle(5);
      conclude();
   end
endmodule : tb_input_interrupt_mask_control
